// *** test_two_speed_start_fail_safe_clock.sv ***
// test_two_speed_start_fail_safe_clock: self-checking bench of the supervisor
// assumes tsfc_pkg and tsfc_osc_model; short counts keep the run brief
`timescale 1ns/1ps
module test_two_speed_start_fail_safe_clock import tsfc_pkg::*;;
  logic        ref_clk, sys_rst, failMonitorEnable, oscFailFlagClear;
  logic        oscFailIrqEnable, sleepEnter, wakeUp, extRun, secRun;
  logic [2:0]  oscModeCfg, sysClockSel;
  logic [1:0]  clockSourceSelect;
  logic [3:0]  internalFreqSelect, internalFreqOut;
  logic        startupDoneStatus, oscFailFlag, oscFailIrq, secondaryOscReady;
  logic        extOscPin, secondaryOscPin, lowFreqOscPin, secondaryOscReadyIn;
  logic [31:0] rng;
  int          err_total, n_tests;
  tsfc_clock_supervisor #(.StartupCount(8), .FailDetPer(4)) dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .oscModeCfg(oscModeCfg),
    .failMonitorEnable(failMonitorEnable), .clockSourceSelect(clockSourceSelect),
    .internalFreqSelect(internalFreqSelect), .oscFailFlagClear(oscFailFlagClear),
    .oscFailIrqEnable(oscFailIrqEnable), .sleepEnter(sleepEnter), .wakeUp(wakeUp),
    .extOscPin(extOscPin), .secondaryOscPin(secondaryOscPin),
    .lowFreqOscPin(lowFreqOscPin), .secondaryOscReadyIn(secondaryOscReadyIn),
    .startupDoneStatus(startupDoneStatus), .oscFailFlag(oscFailFlag),
    .oscFailIrq(oscFailIrq), .sysClockSel(sysClockSel),
    .internalFreqOut(internalFreqOut), .secondaryOscReady(secondaryOscReady));
  tsfc_osc_model osc (
    .ref_clk(ref_clk), .extRun(extRun), .secRun(secRun), .extOscPin(extOscPin),
    .secondaryOscPin(secondaryOscPin), .lowFreqOscPin(lowFreqOscPin),
    .secondaryOscReadyIn(secondaryOscReadyIn));
  //////////////////////////////////////////////////////////////////////////
  // expectation helpers
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // crystal and internal-only modes boot on the internal block, others on config
  function automatic logic [3:0] bootSel(input logic [2:0] m);
    if (m <= FOSC_HIGH_GAIN || m == FOSC_INTERNAL) return 4'(SRC_INTERNAL);
    return 4'(SRC_CONFIG);
  endfunction
  function automatic logic [3:0] obs(input int w);
    case (w)
      0: return 4'(sysClockSel);
      1: return 4'(oscFailFlag);
      2: return 4'(startupDoneStatus);
      default: return 4'(secondaryOscReady);
    endcase
  endfunction
  //////////////////////////////////////////////////////////////////////////
  // drivers and checks, all on the falling edge
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // bounded wait, then compare whatever is there
  task automatic waitOut(input int w, input logic [3:0] e, input int n);
    for (int i = 0; i < n && obs(w) !== e; i++) tick(1);
    chk(obs(w), e);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic boot(input logic [2:0] m, input logic fme);
    oscModeCfg = m;
    failMonitorEnable = fme;
    clockSourceSelect = SEL_CONFIG;
    sys_rst = 1'b1;
    tick(20);
    chk(4'(sysClockSel), 4'(SRC_INTERNAL));
    sys_rst = 1'b0;
  endtask
  task automatic end_sim;
    $display("errors %0d, checks %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    #2000000;
    err_total++;
    end_sim();
  end
  // main sequence
  initial begin
    sys_rst = 1'b1;
    {oscModeCfg, clockSourceSelect, internalFreqSelect} = '0;
    {failMonitorEnable, oscFailFlagClear, oscFailIrqEnable} = '0;
    {sleepEnter, wakeUp, secRun} = '0;
    extRun = 1'b1;
    rng = 32'h8;
    err_total = 0;
    n_tests = 0;
    // crystal and external clock codes 0 to 6: boot, fail, recover; code 4 stays dead and is flagged again
    for (int m = 0; m < 7; m++) begin
      rng = xorshift(rng);
      internalFreqSelect = rng[3:0];
      oscFailIrqEnable = rng[4];
      boot(3'(m), 1'b1);
      tick(20);
      chk(4'(sysClockSel), bootSel(3'(m)));
      waitOut(0, 4'(SRC_CONFIG), 200);
      if (m <= 2) chk(4'(startupDoneStatus), 4'h1);
      extRun = 1'b0;
      tick(100);
      chk(4'(oscFailFlag), 4'h0);
      waitOut(1, 4'h1, 400);
      tick(2);
      chk(4'(sysClockSel), 4'(SRC_INTERNAL));
      chk(internalFreqOut, internalFreqSelect);
      chk(4'(oscFailIrq), 4'(oscFailIrqEnable));
      extRun = (m != 4);
      tick(100);
      chk(4'(oscFailFlag), 4'h1);
      chk(4'(sysClockSel), 4'(SRC_INTERNAL));
      clockSourceSelect = 2'h2;
      tick(2);
      pulse(oscFailFlagClear);
      tick(2);
      chk(4'(oscFailFlag), 4'h0);
      clockSourceSelect = SEL_CONFIG;
      tick(3);
      chk(4'(sysClockSel), bootSel(3'(m)));
      waitOut(0, 4'(SRC_CONFIG), 200);
      if (m == 4) waitOut(1, 4'h1, 600);
      extRun = 1'b1;
    end
    // sleep mid start-up aborts the count, wake restarts it
    boot(FOSC_MID_GAIN, 1'b1);
    tick(50);
    pulse(sleepEnter);
    tick(100);
    chk(4'(startupDoneStatus), 4'h0);
    pulse(wakeUp);
    tick(40);
    chk(4'(startupDoneStatus), 4'h0);
    waitOut(2, 4'h1, 200);
    // monitor disabled: a dead crystal goes unflagged
    boot(FOSC_HIGH_GAIN, 1'b0);
    waitOut(2, 4'h1, 300);
    extRun = 1'b0;
    tick(500);
    chk(4'(oscFailFlag), 4'h0);
    extRun = 1'b1;
    // internal-only configuration: nothing external to wait for or watch
    boot(FOSC_INTERNAL, 1'b1);
    extRun = 1'b0;
    tick(400);
    chk(4'(sysClockSel), bootSel(FOSC_INTERNAL));
    chk(4'(oscFailFlag), 4'h0);
    extRun = 1'b1;
    // secondary oscillator: fail and recover
    boot(FOSC_EXT_HIGH, 1'b1);
    secRun = 1'b1;
    waitOut(3, 4'h1, 200);
    clockSourceSelect = SEL_SECONDARY;
    waitOut(0, 4'(SRC_SECONDARY), 20);
    secRun = 1'b0;
    waitOut(1, 4'h1, 600);
    chk(4'(sysClockSel), 4'(SRC_INTERNAL));
    clockSourceSelect = 2'h3;
    tick(2);
    pulse(oscFailFlagClear);
    secRun = 1'b1;
    waitOut(3, 4'h1, 200);
    clockSourceSelect = SEL_SECONDARY;
    tick(3);
    chk(4'(sysClockSel), 4'(SRC_SECONDARY));
    end_sim();
  end
endmodule

// *** tsfc_clock_supervisor.sv ***
// tsfc_clock_supervisor: start-up timer, two-speed start-up and clock fail monitor
// assumes oscillator clocks arrive as plain pin levels sampled on ref_clk
//
// Contract
// - crystal modes wait 1024 oscillations before use
// - two-speed start-up off unless crystal mode
// - count done sets status, switches to external
// - sleep aborts start-up count, status stays clear
// - monitor active only when its enable set
// - monitor covers crystal, external and secondary
// - falling edges watched, low-freq osc time base
// - failure declared within 32 to 96 periods
// - failure selects internal source, sets fail flag
// - interrupt when fail flag and enable set
// - stay internal until firmware clears condition
// - internal select code resets start-up timer
// - crystal recovery restarts timer, then switches back
// - external clock recovery switches immediately
// - secondary recovery switches immediately after select
// - still failed ext clock or secondary sets flag again; dead crystal stays internal, unflagged
// - crystal monitor waits timer; timer after reset, wake
// - external clock monitor active right after wake
// - monitor enable does not force two-speed start-up; it runs in crystal modes only
`timescale 1ns/1ps
module tsfc_clock_supervisor
  import tsfc_pkg::*;
#(
  parameter int unsigned StartupCount = STARTUP_COUNT,
  parameter int unsigned FailDetPer   = FAIL_DET_PER
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // configuration words
  input  wire logic [2:0] oscModeCfg,
  input  wire logic       failMonitorEnable,
  // firmware controls
  input  wire logic [1:0] clockSourceSelect,
  input  wire logic [3:0] internalFreqSelect,
  input  wire logic       oscFailFlagClear,
  input  wire logic       oscFailIrqEnable,
  input  wire logic       sleepEnter,
  input  wire logic       wakeUp,
  // oscillator pins
  input  wire logic       extOscPin,
  input  wire logic       secondaryOscPin,
  input  wire logic       lowFreqOscPin,
  input  wire logic       secondaryOscReadyIn,
  // status and clock select outputs
  output logic            startupDoneStatus,
  output logic            oscFailFlag,
  output logic            oscFailIrq,
  output logic [2:0]      sysClockSel,
  output logic [3:0]      internalFreqOut,
  output logic            secondaryOscReady
);

  localparam int CW = $clog2(StartupCount + 1);
  localparam int FW = $clog2(FailDetPer + 1);
  localparam logic [CW-1:0] StartupLast = CW'(StartupCount);
  localparam logic [FW-1:0] FailLast    = FW'(FailDetPer);
  // the 32..96 window scaled to the detect count, so short test counts still check
  localparam int FailMinCnt = FailDetPer * FAIL_MIN_PER / FAIL_DET_PER;
  localparam int FailMaxCnt = FailDetPer * FAIL_MAX_PER / FAIL_DET_PER;

  ////////////////////////////////////////////////////////////////////////
  // three-stage synchronisers; first stage feeds only the second
  logic [2:0] extS, secS, lfS, rdyS;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      extS <= 3'h0;
      secS <= 3'h0;
      lfS  <= 3'h0;
      rdyS <= 3'h0;
    end else begin
      extS <= {extS[1:0], extOscPin};
      secS <= {secS[1:0], secondaryOscPin};
      lfS  <= {lfS[1:0], lowFreqOscPin};
      rdyS <= {rdyS[1:0], secondaryOscReadyIn};  // ready comes from the oscillator side
    end
  end

  // a change counts once stages two and three agree
  logic extLvl_q, secLvl_q, lfLvl_q;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      extLvl_q <= 1'b0;
      secLvl_q <= 1'b0;
      lfLvl_q  <= 1'b0;
    end else begin
      if (extS[1] == extS[2]) extLvl_q <= extS[2];
      if (secS[1] == secS[2]) secLvl_q <= secS[2];
      if (lfS[1] == lfS[2])   lfLvl_q  <= lfS[2];
    end
  end

  logic extLvlD_q, secLvlD_q, lfLvlD_q;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      extLvlD_q <= 1'b0;
      secLvlD_q <= 1'b0;
      lfLvlD_q  <= 1'b0;
    end else begin
      extLvlD_q <= extLvl_q;
      secLvlD_q <= secLvl_q;
      lfLvlD_q  <= lfLvl_q;
    end
  end

  // edges trusted only once the chains hold real pin levels; a pin high
  // at reset release would otherwise pass for a fresh rising edge
  logic [2:0] fill_q;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fill_q <= 3'h0;
    end else if (fill_q != SYNC_FILL) begin
      fill_q <= fill_q + 3'h1;
    end
  end
  logic edgeArm;
  assign edgeArm = fill_q == SYNC_FILL;

  logic extRise, extFall, secFall, lfRise;
  assign extRise = edgeArm & extLvl_q & ~extLvlD_q;
  assign extFall = edgeArm & ~extLvl_q & extLvlD_q;
  assign secFall = edgeArm & ~secLvl_q & secLvlD_q;
  assign lfRise  = edgeArm & lfLvl_q & ~lfLvlD_q;

  ////////////////////////////////////////////////////////////////////////
  // mode decode
  logic crystalMode, extClkMode, cfgHasOsc;
  assign crystalMode = (oscModeCfg == FOSC_LOW_GAIN) || (oscModeCfg == FOSC_MID_GAIN)
                    || (oscModeCfg == FOSC_HIGH_GAIN);
  assign extClkMode  = (oscModeCfg == FOSC_EXT_RC) || (oscModeCfg == FOSC_EXT_LOW)
                    || (oscModeCfg == FOSC_EXT_MID) || (oscModeCfg == FOSC_EXT_HIGH);
  assign cfgHasOsc   = crystalMode | extClkMode;
  logic selInternal, selConfig, selSecondary;
  assign selInternal  = clockSourceSelect[1];              // 1x codes
  assign selConfig    = clockSourceSelect == SEL_CONFIG;
  assign selSecondary = clockSourceSelect == SEL_SECONDARY;

  ////////////////////////////////////////////////////////////////////////
  // start-up timer: counts external rising edges while awake
  logic [CW-1:0] stCnt_q;
  logic          stDone_q;
  logic          asleep_q;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      asleep_q <= 1'b0;
    end else if (sleepEnter) begin
      asleep_q <= 1'b1;
    end else if (wakeUp) begin
      asleep_q <= 1'b0;
    end
  end

  // reset clears timer; sleep, wake and 1x restart it
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stCnt_q  <= '0;
      stDone_q <= 1'b0;
    end else if (sleepEnter || wakeUp || selInternal) begin
      stCnt_q  <= '0;
      stDone_q <= 1'b0;
    end else if (crystalMode && !asleep_q && !stDone_q && extRise) begin
      if (stCnt_q == StartupLast - CW'(1)) begin
        stDone_q <= 1'b1;
      end
      stCnt_q <= stCnt_q + CW'(1);
    end
  end

  // timer ready: crystal waits count, external clocks need none
  logic oscReady;
  assign oscReady = extClkMode ? !asleep_q : (crystalMode & stDone_q);

  ////////////////////////////////////////////////////////////////////////
  // fail monitor: a falling edge of the watched source restarts the low-frequency window
  logic monActive;
  assign monActive = failMonitorEnable && !asleep_q && (
                     (selSecondary) ||
                     (selConfig && cfgHasOsc && oscReady) ||
                     (selInternal && oscFailFlag));
  logic          monFall;
  assign monFall = selSecondary ? secFall : extFall;
  logic [FW-1:0] lfCnt_q;
  logic          failDet;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lfCnt_q <= '0;
    end else if (!monActive || monFall) begin
      lfCnt_q <= '0;
    end else if (lfRise && lfCnt_q != FailLast) begin
      lfCnt_q <= lfCnt_q + FW'(1);
    end
  end
  // no detection while a 1x code is selected; a still-dead external clock or secondary is flagged once reselected, a dead crystal is not
  assign failDet = monActive && !selInternal && (lfCnt_q == FailLast);

  ////////////////////////////////////////////////////////////////////////
  // fail flag: set wins over firmware clear, never self-clears
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      oscFailFlag <= 1'b0;
    end else if (failDet) begin
      oscFailFlag <= 1'b1;
    end else if (oscFailFlagClear) begin
      oscFailFlag <= 1'b0;
    end
  end

  // fail-safe latch held until firmware sequence completes
  logic failSafe_q;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      failSafe_q <= 1'b0;
    end else if (failDet) begin
      failSafe_q <= 1'b1;
    end else if (!oscFailFlag && ((selConfig && oscReady) || selSecondary)) begin
      failSafe_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // clock source choice; two-speed runs internal while timer counts
  tsfc_src_t srcD;
  always_comb begin
    srcD = SRC_INTERNAL;
    if (failDet || (failSafe_q && (oscFailFlag || selInternal))) begin
      srcD = SRC_INTERNAL;
    end else if (selSecondary) begin
      srcD = SRC_SECONDARY;
    end else if (selConfig && oscModeCfg == FOSC_INTERNAL) begin
      srcD = SRC_INTERNAL;
    end else if (selConfig && oscReady) begin
      srcD = SRC_CONFIG;
    end else if (selConfig && crystalMode && failMonitorEnable) begin
      srcD = SRC_INTERNAL;
    end else if (selConfig && crystalMode) begin
      srcD = SRC_INTERNAL;
    end else begin
      srcD = SRC_INTERNAL;
    end
  end

  // registered outputs
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sysClockSel       <= SRC_INTERNAL;
      startupDoneStatus <= 1'b0;
      oscFailIrq        <= 1'b0;
      internalFreqOut   <= 4'h0;
      secondaryOscReady <= 1'b0;
    end else begin
      sysClockSel       <= srcD;
      startupDoneStatus <= stDone_q;
      oscFailIrq        <= oscFailFlag & oscFailIrqEnable;
      internalFreqOut   <= internalFreqSelect;
      if (rdyS[1] == rdyS[2]) secondaryOscReady <= rdyS[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions
  property p_irq;
    @(posedge ref_clk) disable iff (sys_rst)
      (oscFailFlag && oscFailIrqEnable) |=> oscFailIrq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");

  property p_flag_sticky;
    @(posedge ref_clk) disable iff (sys_rst)
      (oscFailFlag && !oscFailFlagClear) |=> oscFailFlag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

  property p_fail_internal;
    @(posedge ref_clk) disable iff (sys_rst)
      failDet |=> (sysClockSel == SRC_INTERNAL) && oscFailFlag;
  endproperty
  a_fail_internal: assert property (p_fail_internal) else $error("no switch on fail");

  property p_sleep_abort;
    @(posedge ref_clk) disable iff (sys_rst)
      sleepEnter |=> ##1 !startupDoneStatus;
  endproperty
  a_sleep_abort: assert property (p_sleep_abort) else $error("sleep kept status");

  property p_monitor_off;
    @(posedge ref_clk) disable iff (sys_rst)
      !failMonitorEnable |-> !failDet;
  endproperty
  a_monitor_off: assert property (p_monitor_off) else $error("monitor ran disabled");

  property p_sel_reset;
    @(posedge ref_clk) disable iff (sys_rst)
      selInternal |=> (stCnt_q == '0) && !stDone_q;
  endproperty
  a_sel_reset: assert property (p_sel_reset) else $error("timer not reset");

  property p_no_ext_early;
    @(posedge ref_clk) disable iff (sys_rst)
      (crystalMode && !stDone_q && !selSecondary && !failSafe_q) |=> sysClockSel != SRC_CONFIG;
  endproperty
  a_no_ext_early: assert property (p_no_ext_early) else $error("crystal used early");

  property p_fail_window;
    @(posedge ref_clk) disable iff (sys_rst)
      failDet |-> int'(lfCnt_q) >= FailMinCnt && int'(lfCnt_q) <= FailMaxCnt;
  endproperty
  a_fail_window: assert property (p_fail_window) else $error("fail outside window");

  property p_ext_ready;
    @(posedge ref_clk) disable iff (sys_rst)
      (extClkMode && selConfig && !asleep_q && !failSafe_q && !failDet) |=> sysClockSel == SRC_CONFIG;
  endproperty
  a_ext_ready: assert property (p_ext_ready) else $error("ext clock not used");

  c_fail: cover property (@(posedge ref_clk) disable iff (sys_rst) failDet);
  c_done: cover property (@(posedge ref_clk) disable iff (sys_rst) $rose(startupDoneStatus));
  c_recover: cover property (@(posedge ref_clk) disable iff (sys_rst) $fell(failSafe_q));
endmodule

// *** tsfc_osc_model.sv ***
// tsfc_osc_model: crystal, secondary and low-frequency oscillator pins
// assumes a free-running ref_clk; run controls come from the bench
`timescale 1ns/1ps
module tsfc_osc_model (
  // clock and run controls
  input  wire logic ref_clk,
  input  wire logic extRun,
  input  wire logic secRun,
  // oscillator pins
  output logic      extOscPin,
  output logic      secondaryOscPin,
  output logic      lowFreqOscPin,
  output logic      secondaryOscReadyIn
);
  logic [4:0] cnt;
  logic [4:0] secAge;
  initial begin
    cnt = 5'h0;
    secAge = 5'h0;
    extOscPin = 1'b0;
    secondaryOscPin = 1'b0;
    lowFreqOscPin = 1'b0;
    secondaryOscReadyIn = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////
  // a stopped clock freezes at its last level, as a dead crystal does
  always @(negedge ref_clk) begin
    cnt <= cnt + 5'h1;
    if (extRun && cnt[1:0] == 2'h3) extOscPin <= ~extOscPin;
    if (secRun && cnt[2:0] == 3'h7) secondaryOscPin <= ~secondaryOscPin;
    if (cnt == 5'h1f) lowFreqOscPin <= ~lowFreqOscPin;  // slow time base
  end
  // ready only after the secondary has run a while, drops at once
  always @(negedge ref_clk) begin
    secAge <= !secRun ? 5'h0 : (secAge == 5'h1f) ? secAge : secAge + 5'h1;
    secondaryOscReadyIn <= secRun && (secAge == 5'h1f);
  end
endmodule

// *** tsfc_pkg.sv ***
// tsfc_pkg: constants for the two-speed start-up and fail-safe clock block
// assumes nothing beyond a SystemVerilog compiler
package tsfc_pkg;
  // configured oscillator selections
  localparam logic [2:0] FOSC_LOW_GAIN  = 3'h0;
  localparam logic [2:0] FOSC_MID_GAIN  = 3'h1;
  localparam logic [2:0] FOSC_HIGH_GAIN = 3'h2;
  localparam logic [2:0] FOSC_EXT_RC    = 3'h3;
  localparam logic [2:0] FOSC_EXT_LOW   = 3'h4;
  localparam logic [2:0] FOSC_EXT_MID   = 3'h5;
  localparam logic [2:0] FOSC_EXT_HIGH  = 3'h6;
  localparam logic [2:0] FOSC_INTERNAL  = 3'h7;
  // clock source select codes
  localparam logic [1:0] SEL_CONFIG     = 2'h0;
  localparam logic [1:0] SEL_SECONDARY  = 2'h1;
  // start-up timer length in oscillations
  localparam int unsigned STARTUP_COUNT = 1024;
  // fail window in low-frequency periods; detect at 64, inside 32..96
  localparam int unsigned FAIL_MIN_PER  = 32;
  localparam int unsigned FAIL_MAX_PER  = 96;
  localparam int unsigned FAIL_DET_PER  = 64;
  // cycles after reset before pin edges are trusted: three sync stages,
  // the agreed level and its delayed copy
  localparam logic [2:0]  SYNC_FILL     = 3'h5;
  // clock selected on system clock mux
  typedef enum logic [2:0] {
    SRC_INTERNAL  = 3'b001,
    SRC_CONFIG    = 3'b010,
    SRC_SECONDARY = 3'b100
  } tsfc_src_t;
endpackage
